// ===== design/tx_driver_and_crc_config.sv
// Operation
// - Bit 7 inverts second driver pin
// - Bit 6 inverts first driver pin
// - Driver enable bit enables both pins
// - Style field picks drain, push, hi-z, fixed
// - Full swing overrides carrier level reduction
// - Extra-length field extends modulation in carrier clocks
// - Polarity bit inverts selected modulation
// - Selector: none, envelope, external, reserved
// - Hold first overshoot value, drive it out
// - Hold load trim, drive it out
// - Kind field picks CRC5, CRC8, CRC16
// - Seed selector gives initial CRC value
// - Seed table for CRC16 and CRC8
// - CRC5 seeds; code 6 user seed
// - Complement bit inverts CRC before append
// - Append bit sends CRC, else none
// - User seed comes from nonvolatile preset
`timescale 1ns/1ps

module tx_driver_and_crc_config
	import tx_cfg_pkg::*;
#(
	parameter logic [15:0] CRC16_POLY_REFL = 16'h8408,
	parameter logic [15:0] CRC8_POLY_REFL  = 16'h00B8,
	parameter logic [15:0] CRC5_POLY_REFL  = 16'h0012,
	parameter int          EXTRA_W         = 4
)
(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire axil_req_type bus_req,
	output axil_rsp_type      bus_rsp,
	input  wire logic         carrier_in,
	input  wire logic         coded_envelope,
	input  wire logic         external_signal_input,
	input  wire logic [15:0]  user_crc_seed,
	input  wire logic         frame_start,
	input  wire logic         bit_valid,
	input  wire logic         bit_data,
	input  wire logic         frame_end,
	output logic              tx1_out,
	output logic              tx1_oe_n,
	output logic              tx2_out,
	output logic              tx2_oe_n,
	output logic              modulation_out,
	output logic              carrier_full_swing,
	output logic [1:0]        carrier_level_reduction,
	output logic [4:0]        residual_carrier,
	output logic [3:0]        overshoot_first_value,
	output logic [3:0]        load_current_trim,
	output logic [15:0]       crc_word,
	output logic [1:0]        crc_word_kind,
	output logic              crc_word_valid
);

	if (EXTRA_W != 4)
		$error("EXTRA_W must be 4");

	// --------------------------------------------------------------------
	// Register storage
	// --------------------------------------------------------------------
	logic [7:0] driver_mode_ctrl_reg;
	logic [7:0] carrier_amplitude_ctrl_reg;
	logic [7:0] modulation_source_ctrl_reg;
	logic [7:0] overshoot_load_ctrl_reg;
	logic [7:0] tx_checksum_ctrl_reg;

	logic [7:0]  aw_addr_reg;
	logic        aw_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        w_held_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;

	frame_state_type frame_state_reg;
	logic [15:0]     crc_reg;
	logic [15:0]     crc_last_reg;
	logic            mod_prev_reg;
	logic            carrier_prev_reg;
	logic [EXTRA_W-1:0] extra_cnt_reg;

	// Byte address to index; misaligned is unmapped
	function automatic logic [7:0] addr_index(input logic [7:0] addr);
		addr_index = {{ADDR_SHIFT{1'b0}}, addr[7:ADDR_SHIFT]};
	endfunction

	function automatic logic addr_known(input logic [7:0] addr);
		logic [7:0] idx;
		idx = addr_index(addr);
		addr_known = (addr[ADDR_SHIFT-1:0] == 2'h0) &&
			(idx == IDX_DRIVER_MODE || idx == IDX_CARRIER_AMP ||
			 idx == IDX_MOD_SOURCE || idx == IDX_OVERSHOOT ||
			 idx == IDX_TX_CHECKSUM || idx == IDX_TX_STATUS);
	endfunction

	// --------------------------------------------------------------------
	// AXI4-Lite write path
	// --------------------------------------------------------------------
	logic do_write;

	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
		end
		else if (bus_req.awvalid && bus_rsp.awready)
		begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= bus_req.awaddr;
		end
		else if (do_write)
			aw_held_reg <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			w_held_reg <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= 4'h0;
		end
		else if (bus_req.wvalid && bus_rsp.wready)
		begin
			w_held_reg <= 1'b1;
			w_data_reg <= bus_req.wdata;
			w_strb_reg <= bus_req.wstrb;
		end
		else if (do_write)
			w_held_reg <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= addr_known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bus_req.bready)
			bvalid_reg <= 1'b0;
	end

	// Reserved bits masked so they read back zero
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			driver_mode_ctrl_reg       <= REG_RESET;
			carrier_amplitude_ctrl_reg <= REG_RESET;
			modulation_source_ctrl_reg <= REG_RESET;
			overshoot_load_ctrl_reg    <= REG_RESET;
			tx_checksum_ctrl_reg       <= REG_RESET;
		end
		else if (do_write && w_strb_reg[0] && addr_known(aw_addr_reg))
		begin
			unique case (addr_index(aw_addr_reg))
				IDX_DRIVER_MODE:
					driver_mode_ctrl_reg <= w_data_reg[7:0] & MASK_DRIVER_MODE;
				IDX_CARRIER_AMP:
					carrier_amplitude_ctrl_reg <=
						w_data_reg[7:0] & MASK_CARRIER_AMP;
				IDX_MOD_SOURCE:
					modulation_source_ctrl_reg <=
						w_data_reg[7:0] & MASK_MOD_SOURCE;
				IDX_OVERSHOOT:
					overshoot_load_ctrl_reg <= w_data_reg[7:0] & MASK_OVERSHOOT;
				IDX_TX_CHECKSUM:
					tx_checksum_ctrl_reg <= w_data_reg[7:0] & MASK_TX_CHECKSUM;
				default:
					;
			endcase
		end
	end

	// --------------------------------------------------------------------
	// AXI4-Lite read path
	// --------------------------------------------------------------------
	logic [31:0] rd_word;

	always_comb
	begin
		rd_word = '0;
		unique case (addr_index(bus_req.araddr))
			IDX_DRIVER_MODE: rd_word[7:0] = driver_mode_ctrl_reg;
			IDX_CARRIER_AMP: rd_word[7:0] = carrier_amplitude_ctrl_reg;
			IDX_MOD_SOURCE:  rd_word[7:0] = modulation_source_ctrl_reg;
			IDX_OVERSHOOT:   rd_word[7:0] = overshoot_load_ctrl_reg;
			IDX_TX_CHECKSUM: rd_word[7:0] = tx_checksum_ctrl_reg;
			IDX_TX_STATUS:   rd_word = {crc_last_reg, 14'h0000,
				modulation_out, frame_state_reg != FRAME_IDLE};
			default:         ;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
		end
		else if (bus_req.arvalid && bus_rsp.arready)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= addr_known(bus_req.araddr) ? rd_word : '0;
			rresp_reg  <= addr_known(bus_req.araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bus_req.rready)
			rvalid_reg <= 1'b0;
	end

	always_comb
	begin
		bus_rsp.awready = !aw_held_reg && !bvalid_reg;
		bus_rsp.wready  = !w_held_reg && !bvalid_reg;
		bus_rsp.bvalid  = bvalid_reg;
		bus_rsp.bresp   = bresp_reg;
		bus_rsp.arready = !rvalid_reg;
		bus_rsp.rvalid  = rvalid_reg;
		bus_rsp.rdata   = rdata_reg;
		bus_rsp.rresp   = rresp_reg;
	end

	// --------------------------------------------------------------------
	// Antenna drivers
	// --------------------------------------------------------------------
	logic       second_driver_invert;
	logic       first_driver_invert;
	logic       driver_output_enable;
	logic [2:0] driver_output_style;

	assign second_driver_invert = driver_mode_ctrl_reg[DRV_INV2_BIT];
	assign first_driver_invert  = driver_mode_ctrl_reg[DRV_INV1_BIT];
	assign driver_output_enable = driver_mode_ctrl_reg[DRV_EN_BIT];
	assign driver_output_style  =
		driver_mode_ctrl_reg[DRV_STYLE_LSB +: 3];

	// Returns {out, oe_n}; unsupported codes park at high impedance
	function automatic logic [1:0] pin_drive(input logic sig,
		input logic [2:0] style, input logic enable);
		pin_drive = 2'b01;
		if (enable)
		begin
			unique case (style)
				STYLE_PUSH_PULL:  pin_drive = {sig, 1'b0};
				STYLE_OPEN_DRAIN: pin_drive = {1'b0, sig};
				STYLE_FIX_LOW:    pin_drive = 2'b00;
				STYLE_FIX_HIGH:   pin_drive = 2'b10;
				default:          pin_drive = 2'b01;
			endcase
		end
	endfunction

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			tx1_out  <= 1'b0;
			tx1_oe_n <= 1'b1;
			tx2_out  <= 1'b0;
			tx2_oe_n <= 1'b1;
		end
		else
		begin
			{tx1_out, tx1_oe_n} <= pin_drive(carrier_in ^ first_driver_invert,
				driver_output_style, driver_output_enable);
			{tx2_out, tx2_oe_n} <= pin_drive(carrier_in ^ second_driver_invert,
				driver_output_style, driver_output_enable);
		end
	end

	// --------------------------------------------------------------------
	// Modulation source, polarity and overshoot extension
	// --------------------------------------------------------------------
	logic [1:0]         modulation_source_select;
	logic               modulation_polarity_flip;
	logic [EXTRA_W-1:0] overshoot_extra_length;
	logic               mod_sel;
	logic               carrier_rise;

	assign modulation_source_select =
		modulation_source_ctrl_reg[MOD_SEL_LSB +: 2];
	assign modulation_polarity_flip =
		modulation_source_ctrl_reg[MOD_FLIP_BIT];
	assign overshoot_extra_length =
		modulation_source_ctrl_reg[MOD_EXTRA_LSB +: EXTRA_W];
	assign carrier_rise = carrier_in && !carrier_prev_reg;

	always_comb
	begin
		unique case (modulation_source_select)
			SEL_ENVELOPE: mod_sel = coded_envelope ^ modulation_polarity_flip;
			SEL_EXTERNAL: mod_sel =
				external_signal_input ^ modulation_polarity_flip;
			default:      mod_sel = 1'b0;
		endcase
	end

	// Extension counts carrier rising edges after modulation ends
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			mod_prev_reg     <= 1'b0;
			carrier_prev_reg <= 1'b0;
			extra_cnt_reg    <= '0;
		end
		else
		begin
			mod_prev_reg     <= mod_sel;
			carrier_prev_reg <= carrier_in;
			if (mod_prev_reg && !mod_sel)
				extra_cnt_reg <= overshoot_extra_length;
			else if (mod_sel)
				extra_cnt_reg <= '0;
			else if (carrier_rise && extra_cnt_reg != '0)
				extra_cnt_reg <= extra_cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			modulation_out          <= 1'b0;
			carrier_full_swing      <= 1'b0;
			carrier_level_reduction <= 2'h0;
			residual_carrier        <= 5'h00;
			overshoot_first_value   <= 4'h0;
			load_current_trim       <= 4'h0;
		end
		else
		begin
			modulation_out <= mod_sel || (mod_prev_reg && !mod_sel &&
				overshoot_extra_length != '0) || extra_cnt_reg != '0;
			carrier_full_swing <= modulation_source_ctrl_reg[MOD_MAX_BIT];
			carrier_level_reduction <=
				modulation_source_ctrl_reg[MOD_MAX_BIT] ? 2'h0 :
				carrier_amplitude_ctrl_reg[AMP_LEVEL_LSB +: 2];
			residual_carrier <= carrier_amplitude_ctrl_reg[AMP_RESID_LSB +: 5];
			overshoot_first_value <=
				overshoot_load_ctrl_reg[OVS_FIRST_LSB +: 4];
			load_current_trim <=
				overshoot_load_ctrl_reg[OVS_TRIM_LSB +: 4];
		end
	end

	// --------------------------------------------------------------------
	// Transmit CRC generator
	// --------------------------------------------------------------------
	logic [2:0] crc_seed_select;
	logic [1:0] crc_kind_select;
	logic       crc_complement;
	logic       crc_append_enable;

	assign crc_seed_select   = tx_checksum_ctrl_reg[CRC_SEED_LSB +: 3];
	assign crc_kind_select   = tx_checksum_ctrl_reg[CRC_KIND_LSB +: 2];
	assign crc_complement    = tx_checksum_ctrl_reg[CRC_CPL_BIT];
	assign crc_append_enable = tx_checksum_ctrl_reg[CRC_APP_BIT];

	function automatic logic [15:0] kind_mask(input logic [1:0] kind);
		unique case (kind)
			KIND_CRC5:  kind_mask = 16'h001F;
			KIND_CRC8:  kind_mask = 16'h00FF;
			KIND_CRC16: kind_mask = 16'hFFFF;
			default:    kind_mask = 16'h0000;
		endcase
	endfunction

	// Undefined seed codes give zero rather than a guessed value
	function automatic logic [15:0] seed_value(input logic [2:0] code,
		input logic [1:0] kind, input logic [15:0] user);
		seed_value = 16'h0000;
		unique case (code)
			3'h1: seed_value = (kind == KIND_CRC16) ? 16'h6363 : 16'h0012;
			3'h2: seed_value = (kind == KIND_CRC16) ? 16'hA671 :
				(kind == KIND_CRC8) ? 16'h00BF : 16'h0000;
			3'h3: seed_value = (kind == KIND_CRC16) ? 16'hFFFE :
				(kind == KIND_CRC8) ? 16'h00FD : 16'h0000;
			3'h6: seed_value = user;
			3'h7: seed_value = 16'hFFFF;
			default: seed_value = 16'h0000;
		endcase
		seed_value = seed_value & kind_mask(kind);
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] crc,
		input logic din, input logic [1:0] kind);
		logic [15:0] poly;
		poly = 16'h0000;
		unique case (kind)
			KIND_CRC5:  poly = CRC5_POLY_REFL;
			KIND_CRC8:  poly = CRC8_POLY_REFL;
			KIND_CRC16: poly = CRC16_POLY_REFL;
			default:    poly = 16'h0000;
		endcase
		crc_step = ((crc >> 1) ^ ((crc[0] ^ din) ? poly : 16'h0000)) &
			kind_mask(kind);
	endfunction

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			frame_state_reg <= FRAME_IDLE;
			crc_reg         <= 16'h0000;
		end
		else if (frame_start)
		begin
			frame_state_reg <= FRAME_RUN;
			crc_reg <= seed_value(crc_seed_select, crc_kind_select,
				user_crc_seed);
		end
		else
		begin
			unique case (frame_state_reg)
				FRAME_IDLE:
					;
				FRAME_RUN:
				begin
					if (frame_end)
						frame_state_reg <= FRAME_DONE;
					else if (bit_valid)
						crc_reg <= crc_step(crc_reg, bit_data,
							crc_kind_select);
				end
				FRAME_DONE:
					frame_state_reg <= FRAME_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			crc_word       <= 16'h0000;
			crc_word_kind  <= KIND_CRC5;
			crc_word_valid <= 1'b0;
			crc_last_reg   <= 16'h0000;
		end
		else
		begin
			crc_word_valid <= 1'b0;
			if (frame_state_reg == FRAME_RUN && frame_end && !frame_start)
			begin
				crc_last_reg <= crc_reg ^ (crc_complement ?
					kind_mask(crc_kind_select) : 16'h0000);
				if (crc_append_enable)
				begin
					crc_word <= crc_reg ^ (crc_complement ?
						kind_mask(crc_kind_select) : 16'h0000);
					crc_word_kind  <= crc_kind_select;
					crc_word_valid <= 1'b1;
				end
			end
		end
	end

endmodule

// ===== include/tx_cfg_pkg.sv
package tx_cfg_pkg;

	// --------------------------------------------------------------------
	// Register indices and index-to-byte-address shift
	// --------------------------------------------------------------------
	localparam logic [7:0] IDX_DRIVER_MODE  = 8'h28;
	localparam logic [7:0] IDX_CARRIER_AMP  = 8'h29;
	localparam logic [7:0] IDX_MOD_SOURCE   = 8'h2A;
	localparam logic [7:0] IDX_OVERSHOOT    = 8'h2B;
	localparam logic [7:0] IDX_TX_CHECKSUM  = 8'h2C;
	localparam logic [7:0] IDX_TX_STATUS    = 8'h30;
	localparam int         ADDR_SHIFT       = 2;

	// --------------------------------------------------------------------
	// Field positions and masks
	// --------------------------------------------------------------------
	localparam int DRV_INV2_BIT   = 7;
	localparam int DRV_INV1_BIT   = 6;
	localparam int DRV_EN_BIT     = 3;
	localparam int DRV_STYLE_LSB  = 0;
	localparam int AMP_LEVEL_LSB  = 6;
	localparam int AMP_RESID_LSB  = 0;
	localparam int MOD_EXTRA_LSB  = 4;
	localparam int MOD_MAX_BIT    = 3;
	localparam int MOD_FLIP_BIT   = 2;
	localparam int MOD_SEL_LSB    = 0;
	localparam int OVS_FIRST_LSB  = 4;
	localparam int OVS_TRIM_LSB   = 0;
	localparam int CRC_SEED_LSB   = 4;
	localparam int CRC_KIND_LSB   = 2;
	localparam int CRC_CPL_BIT    = 1;
	localparam int CRC_APP_BIT    = 0;

	localparam logic [7:0] MASK_DRIVER_MODE = 8'hCF;
	localparam logic [7:0] MASK_CARRIER_AMP = 8'hDF;
	localparam logic [7:0] MASK_MOD_SOURCE  = 8'hFF;
	localparam logic [7:0] MASK_OVERSHOOT   = 8'hFF;
	localparam logic [7:0] MASK_TX_CHECKSUM = 8'h7F;
	localparam logic [7:0] REG_RESET        = 8'h00;

	// --------------------------------------------------------------------
	// Encodings
	// --------------------------------------------------------------------
	localparam logic [2:0] STYLE_PUSH_PULL  = 3'h0;
	localparam logic [2:0] STYLE_OPEN_DRAIN = 3'h1;
	localparam logic [2:0] STYLE_HIGH_Z     = 3'h2;
	localparam logic [2:0] STYLE_FIX_LOW    = 3'h4;
	localparam logic [2:0] STYLE_FIX_HIGH   = 3'h5;

	localparam logic [1:0] SEL_NONE     = 2'h0;
	localparam logic [1:0] SEL_ENVELOPE = 2'h1;
	localparam logic [1:0] SEL_EXTERNAL = 2'h2;

	localparam logic [1:0] KIND_CRC5  = 2'h0;
	localparam logic [1:0] KIND_CRC8  = 2'h1;
	localparam logic [1:0] KIND_CRC16 = 2'h2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		FRAME_IDLE = 2'b00,
		FRAME_RUN  = 2'b01,
		FRAME_DONE = 2'b11
	} frame_state_type;

	// --------------------------------------------------------------------
	// Bus carriers
	// --------------------------------------------------------------------
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axil_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_type;

endpackage

// ===== tb/field_model.sv
`timescale 1ns/1ps
module field_model
(
	input  wire logic clk,
	input  wire logic tx1_out,
	input  wire logic tx1_oe_n,
	input  wire logic tx2_out,
	input  wire logic tx2_oe_n,
	output logic      pin1,
	output logic      pin2
);
	// ----------------------------------------------------------------
	// Antenna pins
	// ----------------------------------------------------------------
	// No pull on the coil: a released pin wanders, never keeps a level
	logic flick = 1'b0;
	always @(posedge clk) flick <= ~flick;
	assign pin1 = tx1_oe_n ? flick : tx1_out;
	assign pin2 = tx2_oe_n ? ~flick : tx2_out;
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import tx_cfg_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam logic [7:0] DATA_BYTE = 8'hB2;
	logic         clk = 1'b0;
	logic         resetn = 1'b0;
	axil_req_type bus_req = '0;
	axil_rsp_type bus_rsp;
	logic         carrier_in = 0, coded_envelope = 0, car_run = 0;
	logic         external_signal_input = 0, frame_start = 0;
	logic         bit_valid = 0, bit_data = 0, frame_end = 0;
	logic [15:0]  user_crc_seed = 16'h5A3C;
	logic         tx1_out, tx1_oe_n, tx2_out, tx2_oe_n, pin1, pin2;
	logic         modulation_out, carrier_full_swing, crc_word_valid;
	logic [1:0]   carrier_level_reduction, crc_word_kind;
	logic [4:0]   residual_carrier;
	logic [3:0]   overshoot_first_value, load_current_trim;
	logic [15:0]  crc_word;
	logic [31:0]  rd_data;
	logic [7:0]   idx [5] = '{IDX_DRIVER_MODE, IDX_CARRIER_AMP,
		IDX_MOD_SOURCE, IDX_OVERSHOOT, IDX_TX_CHECKSUM};
	logic [7:0]   msk [5] = '{MASK_DRIVER_MODE, MASK_CARRIER_AMP,
		MASK_MOD_SOURCE, MASK_OVERSHOOT, MASK_TX_CHECKSUM};
	int           n_fail = 0, n_compared = 0, cyc = 0;

	tx_driver_and_crc_config dut (.clk, .resetn, .bus_req, .bus_rsp,
		.carrier_in, .coded_envelope, .external_signal_input,
		.user_crc_seed, .frame_start, .bit_valid, .bit_data, .frame_end,
		.tx1_out, .tx1_oe_n, .tx2_out, .tx2_oe_n, .modulation_out,
		.carrier_full_swing, .carrier_level_reduction, .residual_carrier,
		.overshoot_first_value, .load_current_trim, .crc_word,
		.crc_word_kind, .crc_word_valid);
	field_model fm (.clk, .tx1_out, .tx1_oe_n, .tx2_out, .tx2_oe_n,
		.pin1, .pin2);

	always #5 clk = ~clk;
	always @(posedge clk)
	begin
		if (car_run) carrier_in <= ~carrier_in;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task results();
		if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	function logic [7:0] ad(input logic [7:0] i);
		return i << ADDR_SHIFT;
	endfunction
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic ta, tw, ha, hw;
		ta = 0;
		tw = 0;
		@(posedge clk);
		bus_req.awvalid <= 1;
		bus_req.awaddr <= a;
		bus_req.wvalid <= 1;
		bus_req.wdata <= {24'h0, d};
		bus_req.wstrb <= 4'hF;
		bus_req.bready <= 1;
		while (!(ta && tw))
		begin
			@(negedge clk);
			ha = bus_rsp.awready && !ta;
			hw = bus_rsp.wready && !tw;
			@(posedge clk);
			if (ha) bus_req.awvalid <= 0;
			if (hw) bus_req.wvalid <= 0;
			ta = ta | ha;
			tw = tw | hw;
		end
		do @(negedge clk); while (bus_rsp.bvalid !== 1'b1);
		cmp("bresp", bus_rsp.bresp, er);
		@(posedge clk);
		bus_req.bready <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [1:0] er);
		logic t;
		@(posedge clk);
		bus_req.arvalid <= 1;
		bus_req.araddr <= a;
		bus_req.rready <= 1;
		do
		begin
			@(negedge clk);
			t = bus_rsp.arready;
			@(posedge clk);
		end
		while (!t);
		bus_req.arvalid <= 0;
		do @(negedge clk); while (bus_rsp.rvalid !== 1'b1);
		rd_data = bus_rsp.rdata;
		cmp("rresp", bus_rsp.rresp, er);
		@(posedge clk);
		bus_req.rready <= 0;
	endtask
	task settle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	function logic [1:0] pe(input logic [2:0] st, input logic en,
		input logic sg);
		if (!en) return 2'b01;
		case (st)
			STYLE_PUSH_PULL:  return {sg, 1'b0};
			STYLE_OPEN_DRAIN: return {1'b0, sg};
			STYLE_FIX_LOW:    return 2'b00;
			STYLE_FIX_HIGH:   return 2'b10;
			default:          return 2'b01;
		endcase
	endfunction
	function logic [15:0] crc_exp(input logic [1:0] kd, input logic [2:0] cd,
		input logic cp);
		logic [15:0] m, p, c;
		m = kd == KIND_CRC16 ? 16'hFFFF : kd == KIND_CRC8 ? 16'h00FF : 16'h001F;
		p = kd == KIND_CRC16 ? 16'h8408 : kd == KIND_CRC8 ? 16'h00B8 : 16'h0012;
		case (cd)
			3'h1: c = kd == KIND_CRC16 ? 16'h6363 : 16'h0012;
			3'h2: c = kd == KIND_CRC16 ? 16'hA671 : 16'h00BF;
			3'h3: c = kd == KIND_CRC16 ? 16'hFFFE : 16'h00FD;
			3'h6: c = user_crc_seed;
			3'h7: c = 16'hFFFF;
			default: c = 16'h0000;
		endcase
		c = c & m;
		for (int i = 0; i < 8; i++)
			c = (c >> 1) ^ ((c[0] ^ DATA_BYTE[i]) ? p : 16'h0000);
		return c ^ (cp ? m : 16'h0000);
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_regs();
		for (int i = 0; i < 5; i++)
		begin
			rd(ad(idx[i]), RESP_OKAY);
			cmp("reset value", rd_data, {24'h0, REG_RESET});
			wr(ad(idx[i]), 8'hFF, RESP_OKAY);
			rd(ad(idx[i]), RESP_OKAY);
			cmp("writable bits", rd_data, {24'h0, msk[i]});
		end
		wr(8'h04, 8'h55, RESP_SLVERR);
		rd(8'h04, RESP_SLVERR);
		cmp("unmapped read", rd_data, 32'h0);
	endtask
	task t_drive();
		logic [1:0] e1, e2;
		@(posedge clk);
		carrier_in <= 1;
		for (int k = 0; k < 4; k++)
			for (int s = 0; s < 8; s++)
				if (s != 3 && s != 6)
				begin
					wr(ad(IDX_DRIVER_MODE), {~k[0], k[0], 2'b00, k[1], s[2:0]},
						RESP_OKAY);
					e1 = pe(s[2:0], k[1], ~k[0]);
					e2 = pe(s[2:0], k[1], k[0]);
					settle();
					cmp("tx1 oe", tx1_oe_n, e1[0]);
					cmp("tx2 oe", tx2_oe_n, e2[0]);
					cmp("tx1", tx1_out, e1[1]);
					cmp("tx2", tx2_out, e2[1]);
					if (!e1[0]) cmp("pin1", pin1, e1[1]);
					if (!e2[0]) cmp("pin2", pin2, e2[1]);
				end
	endtask
	task t_mod();
		int cnt;
		@(posedge clk);
		coded_envelope <= 1;
		for (int k = 0; k < 8; k++)
		begin
			wr(ad(IDX_MOD_SOURCE), {5'h00, k[2], k[1:0]}, RESP_OKAY);
			settle();
			cmp("mod", modulation_out, (k[1:0] == 1) ? !k[2] :
				(k[1:0] == 2) ? k[2] : 1'b0);
		end
		wr(ad(IDX_MOD_SOURCE), 8'h31, RESP_OKAY);
		repeat (3) @(posedge clk);
		car_run <= 1;
		coded_envelope <= 0;
		cnt = 0;
		repeat (16)
		begin
			@(negedge clk);
			if (modulation_out) cnt++;
		end
		@(posedge clk);
		car_run <= 0;
		cmp("extension", cnt >= 4 && cnt <= 9, 1);
	endtask
	task t_amp();
		wr(ad(IDX_CARRIER_AMP), 8'hD5, RESP_OKAY);
		wr(ad(IDX_MOD_SOURCE), 8'h08, RESP_OKAY);
		wr(ad(IDX_OVERSHOOT), 8'hA5, RESP_OKAY);
		settle();
		cmp("swing", carrier_full_swing, 1);
		cmp("level", carrier_level_reduction, 0);
		cmp("residual", residual_carrier, 5'h15);
		cmp("first", overshoot_first_value, 4'hA);
		cmp("trim", load_current_trim, 4'h5);
		wr(ad(IDX_MOD_SOURCE), 8'h00, RESP_OKAY);
		settle();
		cmp("swing", carrier_full_swing, 0);
		cmp("level", carrier_level_reduction, 3);
	endtask
	task frame(input logic [1:0] kd, input logic [2:0] cd, input logic cp,
		input logic ap);
		logic seen;
		seen = 0;
		wr(ad(IDX_TX_CHECKSUM), {1'b0, cd, kd, cp, ap}, RESP_OKAY);
		@(posedge clk);
		frame_start <= 1;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			frame_start <= 0;
			bit_valid <= 1;
			bit_data <= DATA_BYTE[i];
		end
		@(posedge clk);
		bit_valid <= 0;
		frame_end <= 1;
		@(posedge clk);
		frame_end <= 0;
		repeat (4)
		begin
			@(negedge clk);
			if (crc_word_valid === 1'b1)
			begin
				seen = 1;
				cmp("crc", crc_word, crc_exp(kd, cd, cp));
				cmp("crc kind", crc_word_kind, kd);
			end
		end
		cmp("crc valid", seen, ap);
	endtask
	task t_crc();
		for (int kd = 0; kd < 3; kd++)
			for (int cd = 0; cd < 8; cd++)
				if (cd != 4 && cd != 5 && (kd != 0 || cd < 2 || cd > 5))
					frame(kd[1:0], cd[2:0], cd == 7 || cd == 2, 1'b1);
		frame(KIND_CRC16, 3'h1, 1'b0, 1'b0);
		rd(ad(IDX_TX_STATUS), RESP_OKAY);
		cmp("status crc", rd_data[31:16], crc_exp(KIND_CRC16, 3'h1, 1'b0));
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		t_regs();
		t_drive();
		t_mod();
		t_amp();
		t_crc();
		results();
	end
endmodule

// ===== tb/tx_cfg_asserts.sv
`timescale 1ns/1ps
module tx_cfg_asserts
	import tx_cfg_pkg::*;
(
	input wire logic         clk,
	input wire logic         resetn,
	input wire axil_req_type bus_req,
	input wire axil_rsp_type bus_rsp,
	input wire logic         carrier_full_swing,
	input wire logic [1:0]   carrier_level_reduction,
	input wire logic [15:0]  crc_word,
	input wire logic [1:0]   crc_word_kind,
	input wire logic         crc_word_valid,
	input wire logic         frame_end
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	property p_swing;
		carrier_full_swing |-> carrier_level_reduction == 2'h0;
	endproperty
	a_swing: assert property (p_swing)
		else $error("level reduction kept at full swing");
	property p_pulse;
		crc_word_valid |=> !crc_word_valid;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("crc valid longer than one cycle");
	property p_cause;
		crc_word_valid |-> $past(frame_end);
	endproperty
	a_cause: assert property (p_cause)
		else $error("crc valid without frame end");
	property p_hold;
		!crc_word_valid |-> $stable(crc_word);
	endproperty
	a_hold: assert property (p_hold)
		else $error("crc word moved between results");
	property p_width;
		crc_word_valid && crc_word_kind != KIND_CRC16 |->
			crc_word[15:8] == 8'h00;
	endproperty
	a_width: assert property (p_width)
		else $error("short crc has high bits");
	property p_c5;
		crc_word_valid && crc_word_kind == KIND_CRC5 |->
			crc_word[15:5] == 11'h000;
	endproperty
	a_c5: assert property (p_c5)
		else $error("crc5 wider than five bits");
	property p_bhold;
		bus_rsp.bvalid && !bus_req.bready |=>
			bus_rsp.bvalid && $stable(bus_rsp.bresp);
	endproperty
	a_bhold: assert property (p_bhold)
		else $error("write response dropped early");
	property p_rhold;
		bus_rsp.rvalid && !bus_req.rready |=>
			bus_rsp.rvalid && $stable(bus_rsp.rdata);
	endproperty
	a_rhold: assert property (p_rhold)
		else $error("read data dropped early");
	property p_wlat;
		bus_req.awvalid && bus_rsp.awready && bus_req.wvalid &&
			bus_rsp.wready |-> ##[1:2] bus_rsp.bvalid;
	endproperty
	a_wlat: assert property (p_wlat)
		else $error("write response late");
	c_valid: cover property (crc_word_valid);
	c_swing: cover property (carrier_full_swing);
	c_err: cover property (bus_rsp.bvalid && bus_rsp.bresp == RESP_SLVERR);
endmodule

bind tx_driver_and_crc_config tx_cfg_asserts chk (
	.clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_rsp(bus_rsp),
	.carrier_full_swing(carrier_full_swing),
	.carrier_level_reduction(carrier_level_reduction),
	.crc_word(crc_word), .crc_word_kind(crc_word_kind),
	.crc_word_valid(crc_word_valid), .frame_end(frame_end)
);
